// File: adcc_pkg.sv
// constants and types shared by the converter control block
package adcc_pkg;

  // register offsets on the plain register port
  localparam logic [2:0] ADDR_STATUS_CONTROL_ONE = 3'h0;
  localparam logic [2:0] ADDR_STATUS_CONTROL_TWO = 3'h1;
  localparam logic [2:0] ADDR_RESULT_HIGH_BYTE = 3'h2;
  localparam logic [2:0] ADDR_RESULT_LOW_BYTE = 3'h3;
  localparam logic [2:0] ADDR_COMPARE_VALUE_HIGH = 3'h4;
  localparam logic [2:0] ADDR_COMPARE_VALUE_LOW = 3'h5;
  localparam logic [2:0] ADDR_CONVERTER_CONFIGURATION = 3'h6;

  // converter_configuration fields
  localparam int CFG_LOW_POWER_BIT = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_LONG_SAMPLE_BIT = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_CLK_LSB = 0;

  // status_control_two fields
  localparam int SC2_ACTIVE_BIT = 7;
  localparam int SC2_TRIGGER_BIT = 6;
  localparam int SC2_CMP_EN_BIT = 5;
  localparam int SC2_CMP_DIR_BIT = 4;

  // status_control_one fields
  localparam int SC1_COMPLETE_BIT = 7;
  localparam int SC1_IRQ_EN_BIT = 6;
  localparam int SC1_CONTINUOUS_BIT = 5;
  localparam int SC1_CHANNEL_LSB = 0;

  // field encodings
  localparam logic [1:0] MODE_10BIT = 2'h2;
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  localparam logic [4:0] CHANNEL_OFF = 5'h1F;

  // reset values
  localparam logic [7:0] RST_CONFIGURATION = 8'h00;
  localparam logic [7:0] RST_STATUS_CONTROL_ONE = 8'h1F;
  localparam logic [7:0] RST_STATUS_CONTROL_TWO = 8'h00;
  localparam logic [9:0] RST_RESULT = 10'h000;
  localparam logic [9:0] RST_COMPARE = 10'h000;

  // full-scale and zero-scale codes
  localparam logic [9:0] FULL_SCALE_10 = 10'h3FF;
  localparam logic [9:0] FULL_SCALE_8 = 10'h0FF;
  localparam logic [9:0] ZERO_SCALE = 10'h000;

  // sample window in tenths of conversion clock cycles, rounded up to whole ticks
  localparam int SAMPLE_SHORT_X10 = 35;
  localparam int SAMPLE_LONG_X10 = 235;
  localparam logic [4:0] SAMPLE_SHORT_TICKS = 5'((SAMPLE_SHORT_X10 + 9) / 10);
  localparam logic [4:0] SAMPLE_LONG_TICKS = 5'((SAMPLE_LONG_X10 + 9) / 10);

  // approximation steps per resolution
  localparam logic [4:0] STEPS_10BIT = 5'h0A;
  localparam logic [4:0] STEPS_8BIT = 5'h08;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } adcc_phase_t;

  typedef struct packed {
    adcc_phase_t phase;
    logic [7:0] cfg;
    logic trg_hw;
    logic cmp_en;
    logic cmp_gt;
    logic conversion_complete_flag;
    logic complete_irq_enable;
    logic continuous_select;
    logic [4:0] ch;
    logic [9:0] cmp_val;
    logic [9:0] result;
    logic half_read;
    logic [7:0] rdata;
    logic irq;
    logic sample;
    logic [4:0] chan_out;
    logic low_power;
    logic [2:0] trig_sync;
    logic [2:0] alt_sync;
    logic [2:0] ack_sync;
    logic bus_half;
    logic [2:0] div_cnt;
    logic [4:0] cnt;
    logic [9:0] code;
    logic stop3_d;
  } adcc_state_t;

endpackage

// File: adcc_ctrl.sv
// control logic of the successive-approximation converter
//
// Contract
// - stop3 without async clock aborts conversion, returns to idle.
// - result registers keep their values across stop3.
// - after such stop3, no restart until a new trigger.
// - with async clock, conversion in progress finishes during stop3.
// - in async stop3, only hardware trigger or continuous mode starts.
// - completion in stop3 sets flag and raises interrupt if enabled.
// - stop1/stop2 disable converter; all registers return to reset.
// - configuration holds low power, divider, long sample, mode, clock.
// - mode value 10 selects 10-bit conversions.
// - clock select 00 routes bus clock to the divider.
// - control two bit 7 reads 1 while converting.
// - control two bit 6 selects hardware trigger; 0 is software.
// - control two bit 5 enables compare, bit 4 picks direction.
// - control two bits 3:2 read zero, bits 1:0 written zero.
// - control one bit 7 read-only complete flag, set on completion.
// - control one bit 6 enables completion interrupt.
// - control one bit 5 continuous; clear means one per trigger.
// - control one bits 4:0 choose the input channel.
// - input at or beyond references saturates to full or zero scale.
// - sample window 3.5 or 23.5 conversion clock cycles; the code rounds up to 4 or 24.
// - in 10-bit mode, high read without low read blocks and discards new result.
// - control one write aborts; restarts in software trigger mode unless channel all ones.
`timescale 1ns/1ns
module adcc_ctrl (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic stop3_i,
  input wire logic stop12_i,
  input wire logic hw_trig_i,
  input wire logic alt_clk_i,
  input wire logic async_clk_i,
  input wire logic [10:0] ain_i,
  output logic irq_o,
  output logic sample_o,
  output logic [4:0] channel_o,
  output logic low_power_o
);
  import adcc_pkg::*;

  adcc_state_t r;
  adcc_state_t next_r;
  adcc_state_t rst_val;

  always_comb
  begin
    rst_val = '0;
    rst_val.phase = ST_IDLE;
    rst_val.cfg = RST_CONFIGURATION;
    rst_val.trg_hw = RST_STATUS_CONTROL_TWO[SC2_TRIGGER_BIT];
    rst_val.cmp_en = RST_STATUS_CONTROL_TWO[SC2_CMP_EN_BIT];
    rst_val.cmp_gt = RST_STATUS_CONTROL_TWO[SC2_CMP_DIR_BIT];
    rst_val.conversion_complete_flag = RST_STATUS_CONTROL_ONE[SC1_COMPLETE_BIT];
    rst_val.complete_irq_enable = RST_STATUS_CONTROL_ONE[SC1_IRQ_EN_BIT];
    rst_val.continuous_select = RST_STATUS_CONTROL_ONE[SC1_CONTINUOUS_BIT];
    rst_val.ch = RST_STATUS_CONTROL_ONE[SC1_CHANNEL_LSB +: 5];
    rst_val.chan_out = RST_STATUS_CONTROL_ONE[SC1_CHANNEL_LSB +: 5];
    rst_val.cmp_val = RST_COMPARE;
    rst_val.result = RST_RESULT;
  end

  logic [1:0] div_sel;
  logic [1:0] clk_sel;
  logic is_10bit;
  logic async_sel;
  logic frozen;
  logic stop3_entry;
  logic src_tick;
  logic adck_tick;
  logic [2:0] div_max;
  logic trig_edge;
  logic [4:0] sample_len;
  logic [4:0] steps;
  logic [9:0] sat_code;
  logic [10:0] diff;
  logic cmp_true;
  logic start;
  logic abort;
  logic complete;
  logic transfer;
  logic conversion_complete_flag_clr;

  always_comb
  begin
    next_r = r;
    div_sel = r.cfg[CFG_DIV_LSB +: 2];
    clk_sel = r.cfg[CFG_CLK_LSB +: 2];
    is_10bit = (r.cfg[CFG_MODE_LSB +: 2] == MODE_10BIT);
    async_sel = (clk_sel == CLK_ASYNC);
    // only the async source keeps ticking while stopped
    frozen = stop3_i && !async_sel;
    stop3_entry = stop3_i && !r.stop3_d;
    next_r.stop3_d = stop3_i;

    // pin synchronisers; stage 0 feeds stage 1 only
    next_r.trig_sync = {r.trig_sync[1:0], hw_trig_i};
    next_r.alt_sync = {r.alt_sync[1:0], alt_clk_i};
    next_r.ack_sync = {r.ack_sync[1:0], async_clk_i};
    trig_edge = r.trig_sync[1] && !r.trig_sync[2];

    next_r.bus_half = !r.bus_half;
    unique case (clk_sel)
      CLK_BUS: src_tick = 1'b1;
      CLK_BUS_HALF: src_tick = r.bus_half;
      CLK_ALT: src_tick = r.alt_sync[1] && !r.alt_sync[2];
      CLK_ASYNC: src_tick = r.ack_sync[1] && !r.ack_sync[2];
    endcase
    // divider field, 00 passes source through
    div_max = 3'((4'h1 << div_sel) - 4'h1);
    adck_tick = 1'b0;
    if (src_tick && !frozen)
    begin
      if (r.div_cnt >= div_max)
      begin
        adck_tick = 1'b1;
        next_r.div_cnt = 3'h0;
      end
      else
      begin
        next_r.div_cnt = r.div_cnt + 3'h1;
      end
    end

    sample_len = r.cfg[CFG_LONG_SAMPLE_BIT] ? SAMPLE_LONG_TICKS : SAMPLE_SHORT_TICKS;
    steps = is_10bit ? STEPS_10BIT : STEPS_8BIT;

    if (is_10bit)
      sat_code = ain_i[10] ? FULL_SCALE_10 : ain_i[9:0];
    else
      sat_code = (ain_i[10] || ain_i[9:8] != 2'h0) ? FULL_SCALE_8 : {2'h0, ain_i[7:0]};

    diff = {1'b0, r.code} - {1'b0, r.cmp_val};
    cmp_true = r.cmp_gt ? !diff[10] : diff[10];

    // register writes; the processor is halted in stop, so none arrive then
    abort = 1'b0;
    start = 1'b0;
    conversion_complete_flag_clr = 1'b0;
    if (wr_i)
    begin
      unique case (addr_i)
        ADDR_STATUS_CONTROL_ONE:
        begin
          next_r.complete_irq_enable = wdata_i[SC1_IRQ_EN_BIT];
          next_r.continuous_select = wdata_i[SC1_CONTINUOUS_BIT];
          next_r.ch = wdata_i[SC1_CHANNEL_LSB +: 5];
          // abort then restart in software trigger mode unless channel off
          abort = 1'b1;
          conversion_complete_flag_clr = 1'b1;
          start = !r.trg_hw && (wdata_i[SC1_CHANNEL_LSB +: 5] != CHANNEL_OFF);
        end
        ADDR_STATUS_CONTROL_TWO:
        begin
          next_r.trg_hw = wdata_i[SC2_TRIGGER_BIT];
          next_r.cmp_en = wdata_i[SC2_CMP_EN_BIT];
          next_r.cmp_gt = wdata_i[SC2_CMP_DIR_BIT];
          abort = 1'b1;
        end
        ADDR_COMPARE_VALUE_HIGH:
        begin
          next_r.cmp_val[9:8] = wdata_i[1:0];
          abort = 1'b1;
        end
        ADDR_COMPARE_VALUE_LOW:
        begin
          next_r.cmp_val[7:0] = wdata_i;
          abort = 1'b1;
        end
        ADDR_CONVERTER_CONFIGURATION:
        begin
          next_r.cfg = wdata_i;
          abort = 1'b1;
        end
        default:
        begin
          abort = 1'b0;
        end
      endcase
    end

    // hardware trigger edge starts when idle
    // in async stop3 only hardware trigger or continuous starts
    if (r.trg_hw && trig_edge && !frozen && r.phase == ST_IDLE && r.ch != CHANNEL_OFF)
      start = 1'b1;

    // register reads, answered the following cycle
    next_r.rdata = 8'h00;
    if (rd_i)
    begin
      unique case (addr_i)
        ADDR_STATUS_CONTROL_ONE:
          next_r.rdata = {r.conversion_complete_flag, r.complete_irq_enable, r.continuous_select, r.ch};
        ADDR_STATUS_CONTROL_TWO:
          next_r.rdata = {r.phase != ST_IDLE, r.trg_hw, r.cmp_en, r.cmp_gt, 4'h0};
        ADDR_RESULT_HIGH_BYTE:
        begin
          next_r.rdata = {6'h00, r.result[9:8]};
          // in 10-bit mode a high read opens the blocking window
          if (is_10bit)
            next_r.half_read = 1'b1;
        end
        ADDR_RESULT_LOW_BYTE:
        begin
          next_r.rdata = r.result[7:0];
          next_r.half_read = 1'b0;
          conversion_complete_flag_clr = 1'b1;
        end
        ADDR_COMPARE_VALUE_HIGH:
          next_r.rdata = {6'h00, r.cmp_val[9:8]};
        ADDR_COMPARE_VALUE_LOW:
          next_r.rdata = r.cmp_val[7:0];
        ADDR_CONVERTER_CONFIGURATION:
          next_r.rdata = r.cfg;
        default:
          next_r.rdata = 8'h00;
      endcase
    end

    // conversion sequencer
    complete = 1'b0;
    transfer = 1'b0;
    unique case (r.phase)
      ST_IDLE:
      begin
        next_r.cnt = 5'h00;
      end
      ST_SAMPLE:
      begin
        if (adck_tick)
        begin
          if (r.cnt == sample_len - 5'h01)
          begin
            next_r.code = sat_code;
            next_r.cnt = 5'h00;
            next_r.phase = ST_CONVERT;
          end
          else
          begin
            next_r.cnt = r.cnt + 5'h01;
          end
        end
      end
      ST_CONVERT:
      begin
        // runs on through stop3 when async clock ticks
        if (adck_tick)
        begin
          if (r.cnt == steps - 5'h01)
            complete = 1'b1;
          else
            next_r.cnt = r.cnt + 5'h01;
        end
      end
    endcase

    if (complete)
    begin
      next_r.cnt = 5'h00;
      if (r.cmp_en && !cmp_true)
      begin
        // failed compare: nothing stored, single mode stops
        next_r.phase = r.continuous_select ? ST_SAMPLE : ST_IDLE;
      end
      else if (r.half_read)
      begin
        next_r.phase = ST_SAMPLE;
      end
      else
      begin
        transfer = 1'b1;
        next_r.result = r.cmp_en ? diff[9:0] : r.code;
        next_r.phase = r.continuous_select ? ST_SAMPLE : ST_IDLE;
      end
    end

    // completion sets the flag, winning over a clear
    // completion in stop3 also sets the flag
    if (transfer)
      next_r.conversion_complete_flag = 1'b1;
    else if (conversion_complete_flag_clr)
      next_r.conversion_complete_flag = 1'b0;

    if (abort)
    begin
      next_r.phase = ST_IDLE;
      next_r.cnt = 5'h00;
    end
    if (start)
    begin
      next_r.phase = ST_SAMPLE;
      next_r.cnt = 5'h00;
      next_r.div_cnt = 3'h0;
    end

    // stop3 without async clock abandons the conversion
    // nothing restarts it on exit without a trigger
    if (stop3_entry && !async_sel)
    begin
      next_r.phase = ST_IDLE;
      next_r.cnt = 5'h00;
    end

    next_r.irq = next_r.conversion_complete_flag && next_r.complete_irq_enable;
    next_r.sample = (next_r.phase == ST_SAMPLE);
    next_r.chan_out = next_r.ch;
    next_r.low_power = next_r.cfg[CFG_LOW_POWER_BIT];

    // stop1/stop2 restore every register to reset
    if (stop12_i)
      next_r = rst_val;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      r.phase <= ST_IDLE;
      r.cfg <= RST_CONFIGURATION;
      r.trg_hw <= RST_STATUS_CONTROL_TWO[SC2_TRIGGER_BIT];
      r.cmp_en <= RST_STATUS_CONTROL_TWO[SC2_CMP_EN_BIT];
      r.cmp_gt <= RST_STATUS_CONTROL_TWO[SC2_CMP_DIR_BIT];
      r.conversion_complete_flag <= RST_STATUS_CONTROL_ONE[SC1_COMPLETE_BIT];
      r.complete_irq_enable <= RST_STATUS_CONTROL_ONE[SC1_IRQ_EN_BIT];
      r.continuous_select <= RST_STATUS_CONTROL_ONE[SC1_CONTINUOUS_BIT];
      r.ch <= RST_STATUS_CONTROL_ONE[SC1_CHANNEL_LSB +: 5];
      r.cmp_val <= RST_COMPARE;
      r.result <= RST_RESULT;
      r.half_read <= 1'b0;
      r.rdata <= 8'h00;
      r.irq <= 1'b0;
      r.sample <= 1'b0;
      r.chan_out <= RST_STATUS_CONTROL_ONE[SC1_CHANNEL_LSB +: 5];
      r.low_power <= 1'b0;
      r.trig_sync <= 3'h0;
      r.alt_sync <= 3'h0;
      r.ack_sync <= 3'h0;
      r.bus_half <= 1'b0;
      r.div_cnt <= 3'h0;
      r.cnt <= 5'h00;
      r.code <= ZERO_SCALE;
      r.stop3_d <= 1'b0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign rdata_o = r.rdata;
  assign irq_o = r.irq;
  assign sample_o = r.sample;
  assign channel_o = r.chan_out;
  assign low_power_o = r.low_power;

endmodule // adcc_ctrl

// File: adcc_ctrl_sva.sv
// assertion checker for the converter control block
`timescale 1ns/1ns
module adcc_ctrl_chk
  import adcc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic stop3_i,
  input wire logic stop12_i,
  input wire logic irq_o,
  input wire logic sample_o,
  input wire logic [4:0] channel_o,
  input wire logic low_power_o
);
  logic hw_mode;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  // mirror of trigger select; a hw edge could start sampling behind our back
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      hw_mode <= 1'b0;
    else if (stop12_i)
      hw_mode <= 1'b0;
    else if (wr_i && addr_i == ADDR_STATUS_CONTROL_TWO)
      hw_mode <= wdata_i[SC2_TRIGGER_BIT];
  end
  sequence s_quiet;
    !wr_i && !stop12_i && !stop3_i;
  endsequence
  sequence s_cfg_wr;
    wr_i && addr_i == ADDR_CONVERTER_CONFIGURATION && !stop12_i;
  endsequence
  sequence s_sc1_wr;
    wr_i && addr_i == ADDR_STATUS_CONTROL_ONE && !stop12_i && !hw_mode;
  endsequence
  AST_SC2_LOW_ZERO: assert property (
    rd_i && addr_i == ADDR_STATUS_CONTROL_TWO |=> rdata_o[3:0] == 4'h0)
    else $error("control two low bits set");
  AST_STOP12_WIPE: assert property (
    stop12_i [*2] |-> channel_o == CHANNEL_OFF && !irq_o && !sample_o && !low_power_o)
    else $error("outputs not at reset in stop12");
  AST_LOW_POWER: assert property (
    s_cfg_wr ##1 s_quiet |=> low_power_o == $past(wdata_i[CFG_LOW_POWER_BIT], 2))
    else $error("low power output stale");
  AST_CHANNEL: assert property (
    s_sc1_wr ##1 s_quiet |=> channel_o == $past(wdata_i[4:0], 2))
    else $error("channel output stale");
  AST_IRQ_GATE: assert property (
    s_sc1_wr ##0 !wdata_i[SC1_IRQ_EN_BIT] ##1 s_quiet |=> !irq_o)
    else $error("request without enable");
  AST_RESTART: assert property (
    s_sc1_wr ##0 wdata_i[4:0] != CHANNEL_OFF && !stop3_i ##1 s_quiet |-> ##[0:2] sample_o)
    else $error("no sampling after control one write");
  AST_CH_OFF: assert property (
    s_sc1_wr ##0 wdata_i[4:0] == CHANNEL_OFF ##1 s_quiet [*4] |-> !sample_o)
    else $error("sampling with channel off");
  AST_ACTIVE: assert property (
    rd_i && addr_i == ADDR_STATUS_CONTROL_TWO && sample_o && !stop12_i && !stop3_i
    && !$past(wr_i) && !$past(stop3_i) && !$past(stop12_i) |=> rdata_o[SC2_ACTIVE_BIT])
    else $error("active flag clear while sampling");
endmodule // adcc_ctrl_chk

bind adcc_ctrl adcc_ctrl_chk chk_i (.clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .stop3_i, .stop12_i, .irq_o, .sample_o, .channel_o, .low_power_o);

// File: test_adcc_ctrl.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
module test_adcc_ctrl;
  import adcc_pkg::*;
  localparam logic [2:0] SC1 = ADDR_STATUS_CONTROL_ONE;
  localparam logic [2:0] SC2 = ADDR_STATUS_CONTROL_TWO;
  localparam logic [2:0] RH = ADDR_RESULT_HIGH_BYTE;
  localparam logic [2:0] RL = ADDR_RESULT_LOW_BYTE;
  localparam logic [2:0] CFG = ADDR_CONVERTER_CONFIGURATION;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stop3 = 1'b0;
  logic stop12 = 1'b0;
  logic trig = 1'b0;
  logic aclk = 1'b0;
  logic [10:0] ain = 11'h000;
  logic [7:0] rdata;
  logic irq;
  logic smp;
  logic [4:0] chan;
  logic lp;
  int n_fail = 0;
  int samples_checked = 0;

  adcc_ctrl dut (.clk_sys_i, .nrst_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .stop3_i(stop3), .stop12_i(stop12), .hw_trig_i(trig),
    .alt_clk_i(aclk), .async_clk_i(aclk), .ain_i(ain), .irq_o(irq), .sample_o(smp),
    .channel_o(chan), .low_power_o(lp));

  initial forever #5 clk_sys_i = ~clk_sys_i;
  // unrelated rate so ticks drift against the bus clock
  // even half period never lands on a rising bus edge, so no sampling race
  initial forever #12 aclk = ~aclk;

  task automatic give_verdict;
  begin
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
  begin
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  end
  endtask

  task automatic put(input logic [2:0] a, input logic [7:0] d);
  begin
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    @(posedge clk_sys_i);
  end
  endtask

  task automatic get(input logic [2:0] a, input logic [7:0] e);
  begin
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    @(negedge clk_sys_i);
    chk({2'h0, rdata}, {2'h0, e});
    @(posedge clk_sys_i);
  end
  endtask

  task automatic wait_irq(input int lim);
    int i;
  begin
    i = 0;
    while (irq !== 1'b1 && i < lim)
    begin
      @(negedge clk_sys_i);
      i++;
    end
    if (i >= lim)
    begin
      n_fail++;
      $display("wrong value at %0t: no completion", $time);
      give_verdict();
    end
    else
      @(posedge clk_sys_i);
  end
  endtask

  // writes control one and counts the sample window that follows
  // slack: a free-running source may end the window a few cycles early
  task automatic convert(input logic [7:0] d, input int len, input int slack = 0);
    int n;
  begin
    n = 0;
    addr <= SC1;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    repeat (40)
    begin
      @(negedge clk_sys_i);
      n += int'(smp === 1'b1);
    end
    chk(10'((n <= len && n + slack >= len) ? len : n), 10'(len));
    @(posedge clk_sys_i);
  end
  endtask

  task automatic t_regs;
  begin
    get(SC1, RST_STATUS_CONTROL_ONE);
    get(3'h7, 8'h00);
    put(SC1, 8'h1F);
    get(SC2, 8'h00);
    get(SC1, 8'h1F);
    put(CFG, 8'h98);
    get(CFG, 8'h98);
    chk({9'h0, lp}, 10'h001);
    put(SC2, 8'h0C);
    get(SC2, 8'h00);
  end
  endtask

  task automatic t_full;
  begin
    ain <= 11'h400;
    convert(8'h41, 24);
    chk({9'h0, irq}, 10'h001);
    chk({5'h0, chan}, 10'h001);
    get(SC1, 8'hC1);
    get(RH, 8'h03);
    get(RL, 8'hFF);
    get(SC1, 8'h41);
    get(SC2, 8'h00);
    put(CFG, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      ain <= k ? 11'h000 : 11'h7FF;
      convert(8'h01, 4);
      get(RL, k ? 8'h00 : 8'hFF);
    end
    put(CFG, 8'h08);
    put(SC2, 8'h30);
    put(ADDR_COMPARE_VALUE_HIGH, 8'h01);
    put(ADDR_COMPARE_VALUE_LOW, 8'h00);
    ain <= 11'h200;
    convert(8'h01, 4);
    get(RH, 8'h01);
    get(RL, 8'h00);
    put(SC2, 8'h20);
    convert(8'h01, 4);
    get(SC1, 8'h01);
    put(SC2, 8'h00);
  end
  endtask

  task automatic t_block;
  begin
    put(CFG, 8'h18);
    ain <= 11'h155;
    get(RH, 8'h01);
    put(SC1, 8'h01);
    repeat (80) @(posedge clk_sys_i);
    get(SC1, 8'h01);
    get(SC2, 8'h80);
    get(RL, 8'h00);
    repeat (40) @(posedge clk_sys_i);
    get(SC1, 8'h81);
    get(RH, 8'h01);
    get(RL, 8'h55);
  end
  endtask

  task automatic t_stop3;
  begin
    put(SC1, 8'h41);
    stop3 <= 1'b1;
    repeat (50) @(posedge clk_sys_i);
    stop3 <= 1'b0;
    repeat (50) @(posedge clk_sys_i);
    get(SC1, 8'h41);
    get(SC2, 8'h00);
    get(RH, 8'h01);
    get(RL, 8'h55);
    put(CFG, 8'h0B);
    ain <= 11'h2AA;
    put(SC1, 8'h41);
    stop3 <= 1'b1;
    wait_irq(900);
    stop3 <= 1'b0;
    get(RH, 8'h02);
    get(RL, 8'hAA);
    put(SC2, 8'h40);
    put(SC1, 8'h41);
    stop3 <= 1'b1;
    ain <= 11'h0F0;
    repeat (60) @(posedge clk_sys_i);
    chk({9'h0, irq}, 10'h000);
    trig <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    trig <= 1'b0;
    wait_irq(900);
    stop3 <= 1'b0;
    get(RL, 8'hF0);
  end
  endtask

  task automatic t_stop12;
  begin
    stop12 <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    stop12 <= 1'b0;
    @(posedge clk_sys_i);
    get(CFG, 8'h00);
    get(SC2, 8'h00);
    get(RL, 8'h00);
    chk({5'h0, chan}, 10'h01F);
  end
  endtask

  // clock sources, divider and continuous mode, from reset values
  task automatic t_modes;
  begin
    put(CFG, 8'h20);
    convert(8'h01, 8);
    get(RL, 8'hF0);
    put(CFG, 8'h01);
    convert(8'h01, 8, 1);
    get(RL, 8'hF0);
    put(CFG, 8'h02);
    convert(8'h01, 11, 3);
    get(RL, 8'hF0);
    put(CFG, 8'h00);
    convert(8'h21, 16);
    get(SC1, 8'hA1);
    get(SC2, 8'h80);
    put(SC1, 8'h1F);
    get(SC2, 8'h00);
  end
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    t_regs();
    t_full();
    t_block();
    t_stop3();
    t_stop12();
    t_modes();
    give_verdict();
  end
endmodule // test_adcc_ctrl
